/* File: rtl/ccg_pkg.sv */
// constants for the core and peripheral clock gating block
// assumes one 250 MHz system clock and word-indexed avalon-mm access
//
// Notes on behaviour
// - gear code 3..0 divides core clock 8,4,2,1
// - halt stops core clock, system keeps running
// - reset, nmi or interrupt ends halt
// - sleep suspends system and core clock feeds
// - external interrupt ends sleep, restarts both feeds
// - peripheral clock is undivided system clock, gated
// - enable field 3 runs, 0 stops; reset 3
// - peripheral clock off stops all its consumers
// - low-speed modules keep a feed without it
// - display driver needs no peripheral clock
// - frequency converter needs no peripheral clock
// - prescaler gives 15 taps, 1/1 to 1/16K
// - run bit D0 at 0x4020 starts/stops prescaler
// - prescaler stopped after reset
// - debug-run bit D1 keeps prescaler in debug
// - prescaler only runs with peripheral clock on
// - reserved bits read zero, written zero
// - all three control registers 8 bits, fields 1:0
package ccg_pkg;
  // --------------------------------------------------------------
  // register map, word indices
  // --------------------------------------------------------------
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 32;
  localparam int          REG_W        = 8;
  localparam logic [15:0] PRESCALER_CONTROL_IDX  = 16'h4020;
  localparam logic [15:0] PCLK_CTL_IDX = 16'h5080;
  localparam logic [15:0] CORE_CLOCK_CTL_IDX = 16'h5081;

  // --------------------------------------------------------------
  // fields and reset values
  // --------------------------------------------------------------
  localparam int         RUN_BIT     = 0;
  localparam int         DBG_RUN_BIT = 1;
  localparam int         FIELD_W     = 2;
  localparam logic [1:0] PCKEN_RST   = 2'h3;
  localparam logic [1:0] PCKEN_ON    = 2'h3;
  localparam logic [1:0] GEAR_RST    = 2'h0;
  localparam logic       RUN_RST     = 1'b0;
  localparam logic       DBG_RUN_RST = 1'b0;

  // --------------------------------------------------------------
  // prescaler and gear counters
  // --------------------------------------------------------------
  localparam int TAPS   = 15;
  localparam int GEAR_W = 3;

  // power state, gray along run -> halt -> sleep
  typedef enum logic [1:0] {
    CCG_RUN   = 2'b00,
    CCG_HALT  = 2'b01,
    CCG_SLEEP = 2'b11
  } ccg_pwr_t;
endpackage

/* File: rtl/ccg_top.sv */
// core gear, halt/sleep gating, peripheral gating and prescaler
// assumes core strobes on CORE_CLK_I; only the wake pin is async
//
// The Avalon-MM interface to the registers was decided locally.
module ccg_top #(
  parameter int TAPS_P = ccg_pkg::TAPS
) (
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RST_N_I,
  input  wire logic                       CE_I,
  input  wire logic [ccg_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                       AVS_READ_I,
  input  wire logic                       AVS_WRITE_I,
  input  wire logic [3:0]                 AVS_BYTEENABLE_I,
  input  wire logic [ccg_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  output logic      [ccg_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic                            AVS_WAITREQUEST_O,
  input  wire logic                       HALT_REQ_I,
  input  wire logic                       SLEEP_REQ_I,
  input  wire logic                       NMI_I,
  input  wire logic                       IRQ_I,
  input  wire logic                       EXT_WAKE_I,
  input  wire logic                       DEBUG_MODE_I,
  output logic                            SYS_CLK_EN_O,
  output logic                            CORE_CLK_EN_O,
  output logic                            PERIPH_CLK_EN_O,
  output logic                            INDEP_CLK_EN_O,
  output logic      [TAPS_P-1:0]          PSC_TICK_O
);
  import ccg_pkg::*;

  // --------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------
  // gear code to terminal count of the gear counter
  function automatic logic [GEAR_W-1:0] gear_last(
    input logic [FIELD_W-1:0] code
  );
    logic [GEAR_W:0] div;
    div = (GEAR_W+1)'(1) << code;
    gear_last = GEAR_W'(div - (GEAR_W+1)'(1));
  endfunction

  // low byte with reserved bits zero
  function automatic logic [DATA_W-1:0] rd_word(
    input logic [FIELD_W-1:0] f
  );
    rd_word = {{(DATA_W-FIELD_W){1'b0}}, f};
  endfunction

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic                psc_run;
  logic                psc_dbg_run;
  logic [FIELD_W-1:0]  pcken;
  logic [FIELD_W-1:0]  gear;
  logic [FIELD_W-1:0]  gear_act;
  logic [GEAR_W-1:0]   gear_cnt;
  logic                gear_tick;
  logic                ack;
  logic                req;
  logic                wr_fire;
  logic                rd_fire;
  logic                wake_m;
  logic                wake_s;
  ccg_pwr_t            pwr;
  ccg_pwr_t            next_pwr;
  logic                sys_run;
  logic                pclk_on;
  logic                psc_go;
  logic [TAPS_P-2:0]   psc_cnt;
  logic [TAPS_P-1:0]   next_tick;

  // --------------------------------------------------------------
  // avalon slave: one wait state, then answer
  // --------------------------------------------------------------
  assign req               = (AVS_READ_I | AVS_WRITE_I) & ~ack;
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
  assign wr_fire           = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0];
  assign rd_fire           = AVS_READ_I & ~ack;

  // ack pulses for one cycle after a request is seen
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack <= 1'b0;
    end else if (CE_I) begin
      ack <= req;
    end
  end

  // read data registered in the wait cycle, unmapped reads zero
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AVS_READDATA_O <= '0;
    end else if (CE_I && rd_fire) begin
      if (AVS_ADDRESS_I == PRESCALER_CONTROL_IDX) begin
        AVS_READDATA_O <= rd_word({psc_dbg_run, psc_run});
      end else if (AVS_ADDRESS_I == PCLK_CTL_IDX) begin
        AVS_READDATA_O <= rd_word(pcken);
      end else if (AVS_ADDRESS_I == CORE_CLOCK_CTL_IDX) begin
        AVS_READDATA_O <= rd_word(gear);
      end else begin
        AVS_READDATA_O <= '0;
      end
    end
  end

  // --------------------------------------------------------------
  // control registers, written at the answering edge
  // --------------------------------------------------------------
  // prescaler control: run and debug-run bits
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      psc_run     <= RUN_RST;
      psc_dbg_run <= DBG_RUN_RST;
    end else if (CE_I && wr_fire && AVS_ADDRESS_I == PRESCALER_CONTROL_IDX) begin
      psc_run     <= AVS_WRITEDATA_I[RUN_BIT];
      psc_dbg_run <= AVS_WRITEDATA_I[DBG_RUN_BIT];
    end
  end

  // peripheral clock enable field, reset on
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pcken <= PCKEN_RST;
    end else if (CE_I && wr_fire && AVS_ADDRESS_I == PCLK_CTL_IDX) begin
      pcken <= AVS_WRITEDATA_I[FIELD_W-1:0];
    end
  end

  // core gear field, reset to undivided
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gear <= GEAR_RST;
    end else if (CE_I && wr_fire && AVS_ADDRESS_I == CORE_CLOCK_CTL_IDX) begin
      gear <= AVS_WRITEDATA_I[FIELD_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // wake pin synchroniser
  // --------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_m <= 1'b0;
      wake_s <= 1'b0;
    end else if (CE_I) begin
      wake_m <= EXT_WAKE_I;
      wake_s <= wake_m;
    end
  end

  // --------------------------------------------------------------
  // power state: run, halt, sleep
  // --------------------------------------------------------------
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      CCG_RUN: begin
        if (SLEEP_REQ_I) begin
          next_pwr = CCG_SLEEP;
        end else if (HALT_REQ_I) begin
          next_pwr = CCG_HALT;
        end
      end
      CCG_HALT: begin
        if (NMI_I || IRQ_I) begin
          next_pwr = CCG_RUN;
        end
      end
      CCG_SLEEP: begin
        if (wake_s) begin
          next_pwr = CCG_RUN;
        end
      end
      default: begin
        next_pwr = CCG_RUN;
      end
    endcase
  end

  // reset also ends halt and sleep
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pwr <= CCG_RUN;
    end else if (CE_I) begin
      pwr <= next_pwr;
    end
  end

  assign sys_run = (pwr != CCG_SLEEP);

  // --------------------------------------------------------------
  // core gear divider
  // --------------------------------------------------------------
  assign gear_tick = (gear_cnt == gear_last(gear_act));

  // new gear taken only when a full divided period ends
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gear_cnt <= '0;
      gear_act <= GEAR_RST;
    end else if (CE_I && sys_run) begin
      if (gear_tick) begin
        gear_cnt <= '0;
        gear_act <= gear;
      end else begin
        gear_cnt <= gear_cnt + GEAR_W'(1);
      end
    end
  end

  // --------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------
  assign pclk_on = sys_run && (pcken == PCKEN_ON);
  assign psc_go  = psc_run && pclk_on
                && (!DEBUG_MODE_I || psc_dbg_run);

  // tap k fires once every 2^k running cycles
  always_comb begin
    logic all_ones;
    all_ones     = psc_go;
    next_tick    = '0;
    next_tick[0] = psc_go;
    for (int k = 1; k < TAPS_P; k++) begin
      all_ones     = all_ones && psc_cnt[k-1]; // running carry chain
      next_tick[k] = all_ones;
    end
  end

  // counter holds while stopped so taps stay aligned
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      psc_cnt <= '0;
    end else if (CE_I && psc_go) begin
      psc_cnt <= psc_cnt + (TAPS_P-1)'(1);
    end
  end

  // ticks registered, whole cycles only
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PSC_TICK_O <= '0;
    end else if (CE_I) begin
      PSC_TICK_O <= next_tick;
    end else begin
      PSC_TICK_O <= '0;
    end
  end

  // --------------------------------------------------------------
  // clock enables for downstream gates
  // --------------------------------------------------------------
  // core feed: running state and gear boundary
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CORE_CLK_EN_O <= 1'b0;
    end else begin
      CORE_CLK_EN_O <= CE_I && (next_pwr == CCG_RUN)
                    && (pwr == CCG_RUN) && gear_tick;
    end
  end

  // system, peripheral and independent feeds
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SYS_CLK_EN_O    <= 1'b0;
      PERIPH_CLK_EN_O <= 1'b0;
      INDEP_CLK_EN_O  <= 1'b0;
    end else if (CE_I) begin
      SYS_CLK_EN_O    <= (next_pwr != CCG_SLEEP);
      PERIPH_CLK_EN_O <= (next_pwr != CCG_SLEEP)
                      && (pcken == PCKEN_ON);
      INDEP_CLK_EN_O  <= (next_pwr != CCG_SLEEP);
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence halt_entry_s;
    CE_I && pwr == CCG_RUN && !SLEEP_REQ_I && HALT_REQ_I;
  endsequence

  sequence halt_exit_s;
    CE_I && pwr == CCG_HALT && (NMI_I || IRQ_I);
  endsequence

  sequence gear_start_s(logic [1:0] code);
    CE_I && sys_run && gear_act == code && gear_cnt == '0;
  endsequence

  // divider periods, only while the divider advances
  gear_div8_a: assert property (
    disable iff (!RST_N_I || !CE_I || !sys_run)
    gear_start_s(2'h3) |-> !gear_tick [*7] ##1 gear_tick
  ) else $error("gear 8 period wrong");

  gear_div4_a: assert property (
    disable iff (!RST_N_I || !CE_I || !sys_run)
    gear_start_s(2'h2) |-> !gear_tick [*3] ##1 gear_tick
  ) else $error("gear 4 period wrong");

  gear_div2_a: assert property (
    disable iff (!RST_N_I || !CE_I || !sys_run)
    gear_start_s(2'h1) |-> !gear_tick ##1 gear_tick
  ) else $error("gear 2 period wrong");

  gear_div1_a: assert property (
    gear_start_s(2'h0) |-> gear_tick
  ) else $error("gear 1 missed a tick");

  halt_stops_a: assert property (
    halt_entry_s |=> !CORE_CLK_EN_O && SYS_CLK_EN_O
  ) else $error("halt did not stop core only");

  halt_wake_a: assert property (
    halt_exit_s |=> pwr == CCG_RUN
  ) else $error("halt not left on interrupt");

  sleep_stops_a: assert property (
    pwr == CCG_SLEEP && CE_I && !wake_s |=> !SYS_CLK_EN_O && !CORE_CLK_EN_O
  ) else $error("sleep left a clock running");

  sleep_wake_a: assert property (
    CE_I && pwr == CCG_SLEEP && wake_s |=> SYS_CLK_EN_O && pwr == CCG_RUN
  ) else $error("sleep not ended by wake");

  pclk_gate_a: assert property (
    PERIPH_CLK_EN_O |-> $past(pcken) == PCKEN_ON
  ) else $error("peripheral clock on with field off");

  psc_needs_pclk_a: assert property (
    PSC_TICK_O[0] |-> $past(pclk_on) && $past(psc_run)
  ) else $error("prescaler ran without feed");

  psc_debug_a: assert property (
    CE_I && DEBUG_MODE_I && !psc_dbg_run |=> PSC_TICK_O == '0
  ) else $error("prescaler ran in debug");

  psc_tap1_a: assert property (
    CE_I && psc_go && psc_cnt[0] |=> PSC_TICK_O[1]
  ) else $error("half rate tap missing");

  rd_zero_a: assert property (
    AVS_READ_I && !AVS_WAITREQUEST_O |-> AVS_READDATA_O[DATA_W-1:FIELD_W] == '0
  ) else $error("reserved bits read nonzero");

  gear_hold_a: assert property (
    !gear_tick |=> $stable(gear_act)
  ) else $error("gear changed inside a period");

  pclk_on_a: assert property (
    CE_I && pcken == PCKEN_ON && pwr == CCG_RUN && !SLEEP_REQ_I
      |=> PERIPH_CLK_EN_O
  ) else $error("peripheral clock not fed");

  pclk_off_a: assert property (
    CE_I && pcken != PCKEN_ON |=> !PERIPH_CLK_EN_O
  ) else $error("peripheral clock fed with field off");

  indep_feed_a: assert property (
    CE_I && pwr != CCG_SLEEP && !SLEEP_REQ_I |=> INDEP_CLK_EN_O
  ) else $error("independent feed stopped");

  psc_stop_a: assert property (
    CE_I && !psc_run |=> PSC_TICK_O == '0
  ) else $error("prescaler ticked while stopped");

  psc_hold_a: assert property (
    !psc_go |=> $stable(psc_cnt)
  ) else $error("stopped prescaler moved");

  gear_wr_a: assert property (
    CE_I && AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0]
      && AVS_ADDRESS_I == CORE_CLOCK_CTL_IDX && AVS_WRITEDATA_I[1:0] == 2'h3
      |=> gear == 2'h3
  ) else $error("gear write lost");

  run_wr_a: assert property (
    CE_I && AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0]
      && AVS_ADDRESS_I == PRESCALER_CONTROL_IDX && AVS_WRITEDATA_I[RUN_BIT]
      |=> psc_run
  ) else $error("run bit write lost");
endmodule

/* File: verification/ccg_core_model.sv */
// edge counters standing in for the core and peripheral consumers
// assumes every enable is sampled on the system clock rising edge
module ccg_core_model #(
  parameter int TAPS_P = 15
) (
  input  wire logic              clk_i,
  input  wire logic              clr_i,
  input  wire logic              sys_i,
  input  wire logic              core_i,
  input  wire logic              periph_i,
  input  wire logic              indep_i,
  input  wire logic [TAPS_P-1:0] tick_i,
  output int                     cnt_o [6]
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // consumers
  // ------------------------------------------------------------
  // each consumer counts the clock edges that reach it
  always @(posedge clk_i) begin
    if (clr_i) begin
      cnt_o <= '{default: 0};
    end else begin
      cnt_o[0] <= cnt_o[0] + int'(sys_i);
      cnt_o[1] <= cnt_o[1] + int'(core_i);
      cnt_o[2] <= cnt_o[2] + int'(periph_i);
      cnt_o[3] <= cnt_o[3] + int'(indep_i);
      cnt_o[4] <= cnt_o[4] + int'(tick_i[0]);
      cnt_o[5] <= cnt_o[5] + int'(tick_i[3]);
    end
  end
endmodule

/* File: verification/test_core_and_peripheral_clock_gating.sv */
// self-checking bench for the clock gating block
// assumes word-indexed avalon-mm and one 250 MHz clock
module test_core_and_peripheral_clock_gating;
  timeunit 1ns;
  timeprecision 1ps;
  import ccg_pkg::*;

  logic            clk;
  logic            rst_n;
  logic            rd_i;
  logic            wr_i;
  logic [3:0]      ev;
  logic [3:0]      be;
  logic            wake;
  logic            dbg;
  logic            mclr;
  logic            ce;
  logic [15:0]     addr;
  logic [31:0]     wdata;
  logic [31:0]     rdata;
  logic [31:0]     q;
  logic            waitreq;
  logic            sys_en;
  logic            core_en;
  logic            per_en;
  logic            ind_en;
  logic [TAPS-1:0] tick;
  int              cnt [6];
  int              snap [6];
  int              failures;
  int              n_compared;
  int              cyc;
  int              r;
  int              g;
  int              dv;
  logic [31:0]     regm [logic [15:0]];

  // ------------------------------------------------------------
  // design and consumers
  // ------------------------------------------------------------
  ccg_top #(.TAPS_P(TAPS)) DUT (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_i), .AVS_WRITE_I(wr_i),
    .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .HALT_REQ_I(ev[3]), .SLEEP_REQ_I(ev[2]), .NMI_I(ev[1]),
    .IRQ_I(ev[0]), .EXT_WAKE_I(wake), .DEBUG_MODE_I(dbg),
    .SYS_CLK_EN_O(sys_en), .CORE_CLK_EN_O(core_en),
    .PERIPH_CLK_EN_O(per_en), .INDEP_CLK_EN_O(ind_en),
    .PSC_TICK_O(tick)
  );
  ccg_core_model #(.TAPS_P(TAPS)) u_cons (
    .clk_i(clk), .clr_i(mclr), .sys_i(sys_en), .core_i(core_en),
    .periph_i(per_en), .indep_i(ind_en), .tick_i(tick), .cnt_o(cnt)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // report and end the run
  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // compare one value
  task automatic check(string nm, logic [31:0] seen, logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, e, seen);
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(bit w, logic [15:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_i <= w;
    rd_i <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    @(posedge clk);
  endtask

  // write, keeping only mapped fields in the shadow
  task automatic wr(logic [15:0] a, logic [31:0] d);
    bus(1'b1, a, d);
    if (regm.exists(a)) begin
      regm[a] = d & 32'h3;
    end
  endtask

  // read against the shadow, unmapped reads zero
  task automatic rd(logic [15:0] a);
    bus(1'b0, a, 32'h0);
    check("readdata", q, regm.exists(a) ? regm[a] : 32'h0);
  endtask

  // pulse power events for one cycle
  task automatic ev_pulse(logic [3:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask

  // count consumer edges over n cycles
  task automatic win(int n);
    mclr <= 1'b1;
    @(posedge clk);
    mclr <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
    snap = cnt;
    @(posedge clk);
  endtask

  // core pulses over 64 settled cycles
  task automatic gear_chk(int div);
    repeat (16) @(posedge clk);
    win(64);
    check("core pulses", snap[1], 64 / div);
  endtask

  // prescaler taps 0 and 3 over 64 cycles
  task automatic tick_chk(int t0, int t3);
    repeat (4) @(posedge clk);
    win(64);
    check("tick0", snap[4], t0);
    check("tick3", snap[5], t3);
  endtask

  // ------------------------------------------------------------
  // clock, timeout, sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    {rst_n, rd_i, wr_i, ev, wake, dbg, mclr} = '0;
    {addr, wdata, failures, n_compared, cyc} = '0;
    ce = 1'b1;
    be = 4'hF;
    regm[PRESCALER_CONTROL_IDX] = 32'h0;
    regm[PCLK_CTL_IDX] = 32'h3;
    regm[CORE_CLOCK_CTL_IDX] = 32'h0;
    r = $urandom(32'hAB720AD1);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(PRESCALER_CONTROL_IDX);
    rd(PCLK_CTL_IDX);
    rd(CORE_CLOCK_CTL_IDX);
    wr(16'h4021, 32'h3);
    rd(16'h4021);
    // every gear code, ascending and wrapping 3 to 0 from a random start code
    r = $urandom_range(3);
    for (int i = 0; i < 4; i++) begin
      g = (i + r) % 4;
      dv = 1 << g;
      wr(CORE_CLOCK_CTL_IDX, 32'(g));
      rd(CORE_CLOCK_CTL_IDX);
      gear_chk(dv);
    end
    // write with byte lane 0 off is dropped
    be <= 4'hE;
    bus(1'b1, CORE_CLOCK_CTL_IDX, 32'(3 - g));
    be <= 4'hF;
    rd(CORE_CLOCK_CTL_IDX);
    // peripheral gating
    win(32);
    check("periph", snap[2], 32);
    wr(PCLK_CTL_IDX, 32'h0);
    win(32);
    check("periph", snap[2], 0);
    check("indep", snap[3], 32);
    wr(PCLK_CTL_IDX, 32'h3);
    win(32);
    check("periph", snap[2], 32);
    check("indep", snap[3], 32);
    // prescaler run, debug and gating
    tick_chk(0, 0);
    wr(PRESCALER_CONTROL_IDX, 32'h1);
    tick_chk(64, 8);
    // clock enable low freezes the block
    ce <= 1'b0;
    win(32);
    check("core frozen", snap[1], 0);
    check("tick frozen", snap[4], 0);
    ce <= 1'b1;
    dbg <= 1'b1;
    tick_chk(0, 0);
    wr(PRESCALER_CONTROL_IDX, 32'h3);
    tick_chk(64, 8);
    dbg <= 1'b0;
    wr(PCLK_CTL_IDX, 32'h0);
    tick_chk(0, 0);
    wr(PCLK_CTL_IDX, 32'h3);
    wr(PRESCALER_CONTROL_IDX, 32'h0);
    tick_chk(0, 0);
    // halt, left by interrupt and by nmi
    ev_pulse(4'h8);
    win(32);
    check("core halt", snap[1], 0);
    check("sys halt", snap[0], 32);
    check("per halt", snap[2], 32);
    ev_pulse(4'h1);
    gear_chk(dv);
    ev_pulse(4'h8);
    ev_pulse(4'h2);
    gear_chk(dv);
    // sleep, plain interrupt ignored, wake pin ends it
    ev_pulse(4'h4);
    ev_pulse(4'h1);
    win(32);
    check("sys sleep", snap[0], 0);
    check("core sleep", snap[1], 0);
    check("per sleep", snap[2], 0);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    gear_chk(dv);
    check("sys wake", snap[0], 64);
    end_of_test();
  end
endmodule
